//--- shared/intc_pkg.sv
/*
 * Shared constants for the interrupt source prioritizer: register offsets,
 * reset values, vector addresses, source positions and reset-cause bits.
 * Assumes an 8-bit register port on the system clock.
 */
// Contract
// - Simultaneous requests resolved by default priority 0..26
// - Comparator 1 source: position 26, vector 00038H
// - Break instruction interrupts via 0007EH, unmasked
// - Reset pin resets, start vector 00000H
// - Resets from power-on, watchdog, trap, illegal access
// - Executed opcode FFH triggers trap reset
// - No trap reset while debug emulator runs
// - Two priority bits per source versus in-service bits
// - External pin inputs 0..7, or 0..5 small
// - Rising and falling edge enables separate
// - Request needs mask clear and global enable
// - Flag set by source/software, cleared on acknowledge
// - Flags reset 00H; flag write adds two clocks
// - Three serial channel 0 sources share bit 7
package intc_pkg;
    localparam int          NSRC        = 27;
    localparam int          NEVT        = 6;
    localparam logic [7:0]  OFS_IF      = 8'he0;
    localparam logic [7:0]  OFS_MASK    = 8'he4;
    localparam logic [7:0]  OFS_PRL     = 8'he8;
    localparam logic [7:0]  OFS_PRH     = 8'hec;
    localparam logic [7:0]  OFS_EGP     = 8'hf0;
    localparam logic [7:0]  OFS_EGN     = 8'hf1;
    localparam logic [7:0]  OFS_EVT_ST  = 8'hf2;
    localparam logic [7:0]  OFS_EVT_CLR = 8'hf3;
    localparam logic [7:0]  OFS_EVT_EN  = 8'hf4;
    localparam logic [31:0] RST_IF      = 32'h0000_0000;
    localparam logic [31:0] RST_MASK    = 32'hffff_ffff;
    localparam logic [31:0] RST_PR      = 32'hffff_ffff;
    localparam logic [31:0] FLAG_VALID  = 32'h07ff_ffff;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam int          IDX_SERIAL0 = 7;
    localparam int          IDX_CMP1    = 26;
    localparam int          PIN_IDX [8] = '{1, 2, 3, 4, 5, 6, 14, 15};
    localparam logic [7:0]  VEC_RESET   = 8'h00;
    localparam logic [7:0]  VEC_BREAK   = 8'h7e;
    localparam logic [7:0]  VEC_BASE    = 8'h04;
    localparam logic [7:0]  VEC_CMP1    = 8'h38;
    localparam logic [7:0]  ILLEGAL_OP  = 8'hff;
    localparam logic [1:0]  IF_WR_CLKS  = 2'h2;
    localparam int          EV_PIN      = 0;
    localparam int          EV_POR      = 1;
    localparam int          EV_WDOG     = 2;
    localparam int          EV_TRAP     = 3;
    localparam int          EV_ACCESS   = 4;
    localparam int          EV_BREAK    = 5;

    // Vectors sit two bytes apart, one table entry per source
    function automatic logic [7:0] vec_of(input logic [4:0] idx);
        return VEC_BASE + {2'h0, idx, 1'b0};
    endfunction

    // Byte lane of a 32-bit flag group
    function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] b);
        return w[{b, 3'h0} +: 8];
    endfunction
endpackage

//--- shared/arb_if.sv
/*
 * Carrier between the flag registers and the priority resolver.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/10ps
interface arb_if;
    import intc_pkg::*;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] lvl_lo;
    logic [NSRC-1:0] lvl_hi;
    logic [1:0]      isp;
    logic            win_valid;
    logic [4:0]      win_idx;
    logic [1:0]      win_lvl;
    modport regs (output pend, lvl_lo, lvl_hi, isp, input win_valid, win_idx, win_lvl);
    modport arb  (input pend, lvl_lo, lvl_hi, isp, output win_valid, win_idx, win_lvl);
endinterface

//--- rtl/prio_resolver.sv
/*
 * Combinational priority resolver: picks the pending source with the best
 * programmed level, lowest index on ties, and checks it against in-service.
 * Assumes pending already excludes masked sources.
 */
`timescale 1ns/10ps
module prio_resolver
    import intc_pkg::*;
(
    arb_if.arb a
);
    logic            best_v;
    logic [4:0]      best_i;
    logic [1:0]      best_l;
    logic [1:0]      cur_l;

    // Scan downward so an equal level at a lower index replaces the winner
    always_comb begin
        best_v = 1'b0;
        best_i = 5'h0;
        best_l = 2'h3;
        cur_l  = 2'h3;
        for (int i = NSRC - 1; i >= 0; i--) begin
            cur_l = {a.lvl_hi[i], a.lvl_lo[i]};
            if (a.pend[i] && (!best_v || cur_l <= best_l)) begin
                best_v = 1'b1;
                best_i = 5'(i);
                best_l = cur_l;
            end
        end
    end

    // Level 0 is highest; in-service 3 leaves every level open
    assign a.win_valid = best_v && (best_l <= a.isp);
    assign a.win_idx   = best_i;
    assign a.win_lvl   = best_l;
endmodule // prio_resolver

//--- rtl/irq_source_prioritizer.sv
/*
 * Interrupt and reset source block: request, mask and priority flags, pin
 * edge detection, break interrupt, reset causes and a cause interrupt.
 * Assumes the CPU core acknowledges the presented request with irq_ack and
 * supplies the global enable and in-service bits of its status word.
 */
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
module irq_source_prioritizer
    import intc_pkg::*;
#(
    parameter int NPIN     = 8,
    parameter bit HAS_CMP1 = 1'b1
) (
    input  wire logic            sys_clk,
    input  wire logic            resetn,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic [7:0]           reg_rdata_q,
    input  wire logic [NSRC-1:0] periph_irq,
    input  wire logic            serial_tx_irq,
    input  wire logic            clocked_serial_irq,
    input  wire logic            simple_twowire_irq,
    input  wire logic [NPIN-1:0] external_pin_irq,
    input  wire logic            global_irq_enable,
    input  wire logic            inservice_prio_low,
    input  wire logic            inservice_prio_high,
    input  wire logic            irq_ack,
    input  wire logic            software_break_instr,
    input  wire logic            instr_exec,
    input  wire logic [7:0]      instr_code,
    input  wire logic            debug_emul_active,
    input  wire logic            reset_pin_n,
    input  wire logic            selectable_power_on_reset,
    input  wire logic            watchdog_overflow_reset,
    input  wire logic            illegal_access_reset,
    output logic                 irq_req_q,
    output logic [7:0]           irq_vec_q,
    output logic [1:0]           irq_lvl_q,
    output logic                 swi_req_q,
    output logic [7:0]           swi_vec_q,
    output logic                 reset_req_q,
    output logic [7:0]           reset_vec_q,
    output logic                 wr_stall_q,
    output logic                 evt_irq_q
);
    logic [31:0]     if_q, if_d;
    logic [31:0]     mask_q, mask_d;
    logic [31:0]     prl_q, prl_d;
    logic [31:0]     prh_q, prh_d;
    logic [7:0]      egp_q, egn_q;
    logic [NEVT-1:0] evt_st_q, evt_st_d, evt_en_q;
    logic [NPIN-1:0] pin_s1, pin_s2, pin_s3;
    logic            rpin_s1, rpin_s2;
    logic [4:0]      irq_idx_q, ack_idx_q;
    logic [1:0]      stall_cnt_q, stall_cnt_d;
    logic [31:0]     if_set, ack_clr, lane_mask, lane_val, src_ok;
    logic [NEVT-1:0] evt_raw;
    logic [7:0]      rdata_d;
    logic            trap, any_reset;
    logic            sel_if, sel_mask, sel_prl, sel_prh, sel_egp, sel_egn;
    logic            sel_est, sel_eclr, sel_een;
    arb_if           arb ();

    // Address decode, one word group per flag kind
    assign sel_if   = reg_addr[7:2] == OFS_IF[7:2];
    assign sel_mask = reg_addr[7:2] == OFS_MASK[7:2];
    assign sel_prl  = reg_addr[7:2] == OFS_PRL[7:2];
    assign sel_prh  = reg_addr[7:2] == OFS_PRH[7:2];
    assign sel_egp  = reg_addr == OFS_EGP;
    assign sel_egn  = reg_addr == OFS_EGN;
    assign sel_est  = reg_addr == OFS_EVT_ST;
    assign sel_eclr = reg_addr == OFS_EVT_CLR;
    assign sel_een  = reg_addr == OFS_EVT_EN;
    assign lane_mask = 32'h0000_00ff << {reg_addr[1:0], 3'h0};
    assign lane_val  = {24'h0, reg_wdata} << {reg_addr[1:0], 3'h0};

    // Unfitted sources never raise a flag; without comparator 1 its bit 26 is dropped
    assign src_ok = FLAG_VALID & ~(HAS_CMP1 ? 32'h0 : (32'h1 << IDX_CMP1));

    // Pin edges, channel 0 serial group and peripheral requests
    always_comb begin
        if_set = {5'h0, periph_irq};
        if_set[IDX_SERIAL0] = periph_irq[IDX_SERIAL0] | serial_tx_irq
                              | clocked_serial_irq | simple_twowire_irq;
        for (int i = 0; i < NPIN; i++) begin
            if ((pin_s2[i] && !pin_s3[i] && egp_q[i])
                || (!pin_s2[i] && pin_s3[i] && egn_q[i])) begin
                if_set[PIN_IDX[i]] = 1'b1;
            end
        end
        if_set = if_set & src_ok;
    end

    // Acknowledge clears the presented flag; a same-cycle source set still wins, a same-cycle flag write does not
    assign ack_clr = irq_ack ? (32'h1 << ack_idx_q) : 32'h0; // index the core saw, not a newer winner
    assign if_d    = ((((reg_wr && sel_if) ? ((if_q & ~lane_mask) | (lane_val & lane_mask)) : if_q)
                     & ~ack_clr) | if_set) & src_ok;
    assign mask_d  = (reg_wr && sel_mask) ? ((mask_q & ~lane_mask) | (lane_val & lane_mask)) : mask_q;
    assign prl_d   = (reg_wr && sel_prl) ? ((prl_q & ~lane_mask) | (lane_val & lane_mask)) : prl_q;
    assign prh_d   = (reg_wr && sel_prh) ? ((prh_q & ~lane_mask) | (lane_val & lane_mask)) : prh_q;

    // Resolver inputs: only unmasked pending flags compete
    assign arb.pend   = if_q[NSRC-1:0] & ~mask_q[NSRC-1:0];
    assign arb.lvl_lo = prl_q[NSRC-1:0];
    assign arb.lvl_hi = prh_q[NSRC-1:0];
    assign arb.isp    = {inservice_prio_high, inservice_prio_low};

    prio_resolver u_resolver (
        .a (arb)
    );

    // Trap held off during debug sessions; reset causes gathered for the core
    assign trap      = instr_exec && (instr_code == ILLEGAL_OP) && !debug_emul_active;
    assign any_reset = !rpin_s2 || selectable_power_on_reset || watchdog_overflow_reset
                       || trap || illegal_access_reset;
    assign evt_raw   = {software_break_instr, illegal_access_reset, trap,
                        watchdog_overflow_reset, selectable_power_on_reset, !rpin_s2};
    assign evt_st_d  = (evt_st_q & ~((reg_wr && sel_eclr) ? reg_wdata[NEVT-1:0] : '0)) | evt_raw;

    // Flag writes stretch the writing instruction by two clocks
    assign stall_cnt_d = (reg_wr && sel_if) ? IF_WR_CLKS
                         : ((stall_cnt_q != 2'h0) ? stall_cnt_q - 2'h1 : 2'h0);

    // Read mux; unmapped offsets read zero
    assign rdata_d = !reg_rd  ? RST_BYTE
                   : sel_if   ? byte_of(if_q, reg_addr[1:0])
                   : sel_mask ? byte_of(mask_q, reg_addr[1:0])
                   : sel_prl  ? byte_of(prl_q, reg_addr[1:0])
                   : sel_prh  ? byte_of(prh_q, reg_addr[1:0])
                   : sel_egp  ? egp_q
                   : sel_egn  ? egn_q
                   : sel_est  ? {2'h0, evt_st_q}
                   : sel_een  ? {2'h0, evt_en_q}
                   : RST_BYTE;

    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        pin_s1  <= external_pin_irq;
        pin_s2  <= pin_s1;
        pin_s3  <= pin_s2;
        rpin_s1 <= reset_pin_n;
        rpin_s2 <= rpin_s1;
    end

    // Flag registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            if_q  <= RST_IF;
            mask_q <= RST_MASK;
            prl_q <= RST_PR;
            prh_q <= RST_PR;
        end else begin
            if_q  <= if_d;
            mask_q <= mask_d;
            prl_q <= prl_d;
            prh_q <= prh_d;
        end
    end

    // Edge enables and reset-cause registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            egp_q    <= RST_BYTE;
            egn_q    <= RST_BYTE;
            evt_st_q <= '0;
            evt_en_q <= '0;
        end else begin
            egp_q    <= (reg_wr && sel_egp) ? reg_wdata : egp_q;
            egn_q    <= (reg_wr && sel_egn) ? reg_wdata : egn_q;
            evt_st_q <= evt_st_d;
            evt_en_q <= (reg_wr && sel_een) ? reg_wdata[NEVT-1:0] : evt_en_q;
        end
    end

    // Request to the core, recomputed each clock from the resolver and global enable, low the clock after acknowledge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            irq_req_q <= 1'b0;
            irq_idx_q <= 5'h0;
            ack_idx_q <= 5'h0;
            irq_vec_q <= VEC_RESET;
            irq_lvl_q <= 2'h3;
        end else begin
            irq_req_q <= arb.win_valid && global_irq_enable && !irq_ack;
            irq_idx_q <= arb.win_idx;
            ack_idx_q <= irq_idx_q;
            irq_vec_q <= vec_of(arb.win_idx);
            irq_lvl_q <= arb.win_lvl;
        end
    end

    // Break, reset and stall outputs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            swi_req_q   <= 1'b0;
            swi_vec_q   <= VEC_BREAK;
            reset_req_q <= 1'b0;
            reset_vec_q <= VEC_RESET;
            stall_cnt_q <= 2'h0;
            wr_stall_q  <= 1'b0;
            evt_irq_q   <= 1'b0;
            reg_rdata_q <= RST_BYTE;
        end else begin
            swi_req_q   <= software_break_instr;
            swi_vec_q   <= VEC_BREAK;
            reset_req_q <= any_reset;
            reset_vec_q <= VEC_RESET;
            stall_cnt_q <= stall_cnt_d;
            wr_stall_q  <= stall_cnt_d != 2'h0;
            evt_irq_q   <= |(evt_st_d & evt_en_q);
            reg_rdata_q <= rdata_d;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_trap_op;
        instr_exec && instr_code == ILLEGAL_OP;
    endsequence
    sequence s_flag_write;
        reg_wr && sel_if;
    endsequence
    sequence s_rise_pin0;
        $rose(pin_s2[0]) && egp_q[0];
    endsequence

    chk_trap_reset: assert property (s_trap_op and !debug_emul_active |=> reset_req_q)
        else $error("illegal opcode did not reset");
    chk_debug_no_trap: assert property (s_trap_op and debug_emul_active && rpin_s2
        && !selectable_power_on_reset && !watchdog_overflow_reset && !illegal_access_reset
        |=> !reset_req_q)
        else $error("trap reset during emulation");
    chk_break_vector: assert property (software_break_instr |=> swi_req_q && swi_vec_q == VEC_BREAK)
        else $error("break interrupt missing or wrong vector");
    chk_global_gate: assert property (irq_req_q |-> $past(global_irq_enable))
        else $error("request presented while globally disabled");
    chk_flag_stall: assert property (s_flag_write |=> wr_stall_q [*2])
        else $error("flag write stall not two clocks");
    chk_ack_clear: assert property (irq_ack && !if_set[ack_idx_q] |=> !if_q[$past(ack_idx_q)])
        else $error("acknowledged flag not cleared");
    chk_serial_share: assert property (serial_tx_irq || clocked_serial_irq || simple_twowire_irq
        |=> if_q[IDX_SERIAL0])
        else $error("serial group flag not set");
    chk_cmp1_vector: assert property (irq_req_q && irq_idx_q == 5'(IDX_CMP1) |-> irq_vec_q == VEC_CMP1)
        else $error("comparator 1 vector wrong");
    chk_pin_rise: assert property (s_rise_pin0 |=> if_q[PIN_IDX[0]])
        else $error("rising edge did not set pin flag");
    chk_level_rank: assert property (irq_req_q |-> irq_lvl_q <= $past(arb.isp))
        else $error("request does not outrank in-service level");
endmodule // irq_source_prioritizer

//--- testbench/cpu_core_model.sv
/*
 * CPU core stand-in: acknowledges a presented maskable request after a
 * programmable wait and keeps the vector it took plus an acknowledge count.
 * Assumes the prioritizer drops its request the cycle after acknowledge.
 */
`timescale 1ns/10ps
module cpu_core_model (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       irq_req_q,
    input  wire logic [7:0] irq_vec_q,
    input  wire logic [3:0] ack_delay,
    output logic            irq_ack,
    output logic [7:0]      last_vec,
    output int              ack_cnt
);
    logic [3:0] wait_q;

    // Acknowledge only while a request stands, never on two edges in a row
    always @(posedge sys_clk) begin
        if (!resetn) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
            ack_cnt <= 0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            wait_q  <= 4'h0;
        end else if (irq_req_q && wait_q == ack_delay) begin
            irq_ack  <= 1'b1;
            last_vec <= irq_vec_q;
            ack_cnt  <= ack_cnt + 1;
        end else if (irq_req_q) begin
            wait_q <= wait_q + 4'h1;
        end else begin
            wait_q <= 4'h0; // Request withdrawn, restart the wait
        end
    end
endmodule // cpu_core_model

//--- testbench/irq_source_prioritizer_tb.sv
/*
 * Self-checking bench for the interrupt source prioritizer: register port,
 * arbitration, pin edges, break and reset causes, cause interrupt.
 * Assumes cpu_core_model acknowledges requests on the core side.
 */
`timescale 1ns/10ps
module irq_source_prioritizer_tb;
    import intc_pkg::*;
    logic            sys_clk, resetn, reg_wr, reg_rd, serial_tx_irq, clocked_serial_irq, simple_twowire_irq;
    logic            global_irq_enable, inservice_prio_low, inservice_prio_high, irq_ack, software_break_instr;
    logic            instr_exec, debug_emul_active, reset_pin_n, selectable_power_on_reset, seen_rst;
    logic            watchdog_overflow_reset, illegal_access_reset, irq_req_q, swi_req_q, reset_req_q;
    logic            wr_stall_q, evt_irq_q;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata_q, instr_code, irq_vec_q, swi_vec_q, reset_vec_q, last_vec;
    logic [7:0]      external_pin_irq;
    logic [1:0]      irq_lvl_q;
    logic [3:0]      ack_delay;
    logic [NSRC-1:0] periph_irq;
    int              ack_cnt, acks_seen, error_cnt, num_checks;

    // 40 MHz system clock
    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    irq_source_prioritizer #(.NPIN(8), .HAS_CMP1(1'b1)) dut (
        .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .periph_irq, .serial_tx_irq,
        .clocked_serial_irq, .simple_twowire_irq, .external_pin_irq, .global_irq_enable, .inservice_prio_low,
        .inservice_prio_high, .irq_ack, .software_break_instr, .instr_exec, .instr_code, .debug_emul_active,
        .reset_pin_n, .selectable_power_on_reset, .watchdog_overflow_reset, .illegal_access_reset, .irq_req_q,
        .irq_vec_q, .irq_lvl_q, .swi_req_q, .swi_vec_q, .reset_req_q, .reset_vec_q, .wr_stall_q, .evt_irq_q);
    cpu_core_model core (.sys_clk, .resetn, .irq_req_q, .irq_vec_q, .ack_delay, .irq_ack, .last_vec, .ack_cnt);

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bus tasks; a write also watches the two-cycle stall of flag writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (2) @(negedge sys_clk) check({7'h0, wr_stall_q}, {7'h0, a[7:2] == 6'h38});
        @(negedge sys_clk) check({7'h0, wr_stall_q}, 8'h00);
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk) check(reg_rdata_q, exp);
        @(posedge sys_clk);
    endtask

    task automatic pulse(input logic [NSRC-1:0] m);
        periph_irq <= m;
        @(posedge sys_clk);
        periph_irq <= '0;
        @(posedge sys_clk);
    endtask

    // Wait, bounded, for the core's next acknowledge and compare its vector
    task automatic expect_ack(input logic [7:0] exp);
        for (int n = 0; n < 40 && ack_cnt == acks_seen; n++) @(negedge sys_clk);
        acks_seen++;
        check(8'(ack_cnt - acks_seen), 8'h00);
        check(last_vec, exp);
        @(posedge sys_clk);
    endtask

    task automatic expect_none(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) @(negedge sys_clk) seen |= irq_req_q;
        check({7'h0, seen}, 8'h00);
        check(8'(ack_cnt - acks_seen), 8'h00);
        @(posedge sys_clk);
    endtask

    // Pulse one cause: 1 power-on, 2 watchdog, 3 instruction, 4 access, 5 break
    task automatic cause(input int k, input logic [7:0] code, input logic rst);
        selectable_power_on_reset <= (k == 1);
        watchdog_overflow_reset   <= (k == 2);
        instr_exec                <= (k == 3);
        instr_code                <= code;
        illegal_access_reset      <= (k == 4);
        software_break_instr      <= (k == 5);
        @(posedge sys_clk);
        {selectable_power_on_reset, watchdog_overflow_reset, instr_exec} <= 3'h0;
        {illegal_access_reset, software_break_instr} <= 2'h0;
        @(negedge sys_clk) check({7'h0, reset_req_q}, {7'h0, rst});
        check({7'h0, swi_req_q}, {7'h0, k == 5});
        check(swi_vec_q, 8'h7e);
        @(posedge sys_clk);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the roughly 400 cycles the sequence needs
    initial begin
        #500000;
        error_cnt++;
        results();
    end

    initial begin
        {resetn, reg_wr, reg_rd, serial_tx_irq, clocked_serial_irq, simple_twowire_irq} = '0;
        {software_break_instr, instr_exec, debug_emul_active, selectable_power_on_reset} = '0;
        {watchdog_overflow_reset, illegal_access_reset, global_irq_enable} = '0;
        {reg_addr, reg_wdata, instr_code, external_pin_irq, periph_irq, ack_delay} = '0;
        {reset_pin_n, inservice_prio_high, inservice_prio_low} = 3'h7;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        // Reset values, then unmask every source
        for (int i = 0; i < 4; i++) begin
            rd(OFS_IF + 8'(i), 8'h00);
            rd(OFS_MASK + 8'(i), 8'hff);
            rd(OFS_PRL + 8'(i), 8'hff);
            rd(OFS_PRH + 8'(i), 8'hff);
            wr(OFS_MASK + 8'(i), 8'h00);
        end
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        rd(OFS_EVT_CLR, 8'h00);
        global_irq_enable <= 1'b1;
        // Equal levels fall back to default order, comparator 1 last
        pulse(27'h010_0008);
        expect_ack(8'h0a);
        expect_ack(8'h2c);
        pulse(27'h600_0000);
        expect_ack(8'h36);
        expect_ack(8'h38);
        // Source 20 at level 0 beats source 3 at level 3
        wr(OFS_PRL + 8'h2, 8'hef);
        wr(OFS_PRH + 8'h2, 8'hef);
        pulse(27'h010_0008);
        expect_ack(8'h2c);
        expect_ack(8'h0a);
        wr(OFS_PRL + 8'h2, 8'hff);
        wr(OFS_PRH + 8'h2, 8'hff);
        // Source 4 at level 1 passes in-service level 1, level 3 waits
        wr(OFS_PRH, 8'hef);
        {inservice_prio_high, inservice_prio_low} <= 2'h1;
        pulse(27'h000_0018);
        @(negedge sys_clk) check({6'h0, irq_lvl_q}, 8'h01);
        expect_ack(8'h0c);
        expect_none(10);
        {inservice_prio_high, inservice_prio_low} <= 2'h3;
        expect_ack(8'h0a);
        // Global enable and mask both gate the request, flag still pends
        global_irq_enable <= 1'b0;
        pulse(27'h000_0008);
        expect_none(10);
        wr(OFS_MASK, 8'h08);
        global_irq_enable <= 1'b1;
        expect_none(10);
        rd(OFS_IF, 8'h08);
        wr(OFS_MASK, 8'h00);
        expect_ack(8'h0a);
        rd(OFS_IF, 8'h00);
        wr(OFS_IF, 8'h08); // byte write only while no other flag pends
        expect_ack(8'h0a);
        // Shared serial bit, with a slow core
        ack_delay <= 4'h6;
        for (int s = 0; s < 3; s++) begin
            {serial_tx_irq, clocked_serial_irq, simple_twowire_irq} <= 3'(4 >> s);
            @(posedge sys_clk);
            {serial_tx_irq, clocked_serial_irq, simple_twowire_irq} <= 3'h0;
            expect_ack(8'h12);
        end
        ack_delay <= 4'h0;
        // Pin edges, each edge kind enabled separately
        wr(OFS_EGP, 8'h01);
        external_pin_irq[0] <= 1'b1;
        expect_ack(8'h06);
        external_pin_irq[0] <= 1'b0;
        expect_none(10);
        wr(OFS_EGN, 8'h01);
        external_pin_irq[0] <= 1'b1;
        expect_ack(8'h06);
        external_pin_irq[0] <= 1'b0;
        expect_ack(8'h06);
        wr(OFS_EGP, 8'h80);
        external_pin_irq[7] <= 1'b1;
        expect_ack(8'h22);
        // Every cause sets its status bit; break ignores the global enable
        global_irq_enable <= 1'b0;
        for (int k = 1; k < 6; k++) begin
            cause(k, ILLEGAL_OP, k != 5);
            rd(OFS_EVT_ST, 8'(1 << k));
            wr(OFS_EVT_CLR, 8'hff);
        end
        cause(3, 8'hfe, 1'b0);
        debug_emul_active <= 1'b1;
        cause(3, ILLEGAL_OP, 1'b0);
        debug_emul_active <= 1'b0;
        rd(OFS_EVT_ST, 8'h00);
        // Cause interrupt: raise, mask, unmask, clear
        wr(OFS_EVT_EN, 8'h08);
        cause(3, ILLEGAL_OP, 1'b1);
        @(negedge sys_clk) check({7'h0, evt_irq_q}, 8'h01);
        @(posedge sys_clk);
        wr(OFS_EVT_ST, 8'hff);
        rd(OFS_EVT_ST, 8'h08);
        wr(OFS_EVT_EN, 8'h00);
        @(negedge sys_clk) check({7'h0, evt_irq_q}, 8'h00);
        @(posedge sys_clk);
        wr(OFS_EVT_EN, 8'h08);
        @(negedge sys_clk) check({7'h0, evt_irq_q}, 8'h01);
        @(posedge sys_clk);
        wr(OFS_EVT_CLR, 8'h08);
        @(negedge sys_clk) check({7'h0, evt_irq_q}, 8'h00);
        @(posedge sys_clk);
        // Reset pin, seen through its synchroniser
        reset_pin_n <= 1'b0;
        seen_rst = 1'b0;
        repeat (6) @(negedge sys_clk) seen_rst |= reset_req_q;
        check({7'h0, seen_rst}, 8'h01);
        check(reset_vec_q, 8'h00);
        @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(OFS_EVT_ST, 8'h01);
        results();
    end
endmodule // irq_source_prioritizer_tb
